//--- verilog/cpudc_decoder.sv
// Purpose: Decodes one slice of the core opcode map and paces the fetch stream
// Assumes: Flags and fetch inputs are synchronous to clk
// Notes: The datapath applies shifts and moves; this block only classifies
// Operation
// - Branch word 1110 0011, low byte names condition, next word is target
// - Bit test 0100 uses nibble bit position; 0110 1111 uses temp register
// - 1010 1000 block move, second word is source, two words three cycles
// - 1010 1001 block move, second word is destination, two words three cycles
// - 1010 0101 program-to-data move, second word program address
// - 1011 1110 0100 low nibble 0, 2, 4, 6, a, c or e selects a status bit clear; others are unknown
// - 1011 1111 0100 01xx compares current aux register with aux zero
// - 0111 0111 moves data within data memory in one cycle
// - 1010 1111 port input, second word port address, two cycles
// - 1011 1111 1000 shift then long constant loads accumulator, two cycles
// - 0110 1011 loads accumulator shifted by temp register amount
// - 1011 1001 loads 8-bit constant into accumulator; zero clears it
// - 0110 1001 zero high load low; 0110 1010 zero low load high
// - Aux register short immediate and direct forms take two cycles
// - 1011 1111 0000 1xxx loads aux register from second word
// - Page pointer loads from 9-bit immediate or memory, two cycles
// - 0000 1110 and 0000 1111 load status words in two cycles
// - Prefix 0111 with variants load the temp register in one cycle
// - 0111 0101 loads upper product half in one cycle
// - Condition met when masked flags equal their wanted states
// - Pair field: pin low, test set, test clear, none
module cpudc_decoder
#(
    parameter int WORD_W = 16
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic fetchValid,
    input wire logic [WORD_W-1:0] fetchWord,
    input wire logic accZero,
    input wire logic accNeg,
    input wire logic ovfFlag,
    input wire logic carryFlag,
    input wire logic testFlag,
    input wire logic ioPinLow,
    output logic fetchReady,
    output logic decExpectOperand,
    output logic decValid,
    output cpudc_pkg::cpudc_op_e decOp,
    output logic decUnknown,
    output logic decTwoWord,
    output logic [2:0] decCycles,
    output logic decCondMet,
    output logic [WORD_W-1:0] decWord,
    output logic [WORD_W-1:0] decImm
);
    generate
        if (WORD_W != 16)
        begin : g_width_check
            $error("cpudc_decoder serves 16-bit words only");
        end
    endgenerate

    cpudc_pkg::cpudc_regs_s st_ff;
    cpudc_pkg::cpudc_regs_s nxt_st;
    cpudc_pkg::cpudc_op_e dOp;
    logic dTwo;
    logic [2:0] dCyc;
    logic [15:0] dImm;
    logic [2:0] finCyc;
    cpudc_cond_if condBus ();

    assign condBus.word = st_ff.word;
    assign condBus.accZero = accZero;
    assign condBus.accNeg = accNeg;
    assign condBus.ovfFlag = ovfFlag;
    assign condBus.carryFlag = carryFlag;
    assign condBus.testFlag = testFlag;
    assign condBus.ioPinLow = ioPinLow;

    cpudc_cond_eval u_cond
    (
        .cif(condBus)
    );

    // Classify the incoming first word
    always_comb
    begin
        dOp = cpudc_pkg::OP_NONE;
        dTwo = 1'b0;
        dCyc = cpudc_pkg::CYC_ONE;
        dImm = cpudc_pkg::RST_WORD;
        casez (fetchWord)
            16'b1110_0011_????_????:
            begin
                dOp = cpudc_pkg::OP_BRANCH;
                dTwo = 1'b1;
                dCyc = cpudc_pkg::CYC_SKIP;
            end
            16'b0100_????_????_????: dOp = cpudc_pkg::OP_BITTEST;
            16'b0110_1111_????_????: dOp = cpudc_pkg::OP_BITTEMP;
            16'b1010_1000_????_????:
            begin
                dOp = cpudc_pkg::OP_BLKSRC;
                dTwo = 1'b1;
                dCyc = cpudc_pkg::CYC_MOVE;
            end
            16'b1010_1001_????_????:
            begin
                dOp = cpudc_pkg::OP_BLKDST;
                dTwo = 1'b1;
                dCyc = cpudc_pkg::CYC_MOVE;
            end
            16'b1010_0101_????_????:
            begin
                dOp = cpudc_pkg::OP_BLKPROG;
                dTwo = 1'b1;
                dCyc = cpudc_pkg::CYC_MOVE;
            end
            16'hbe40, 16'hbe42, 16'hbe44, 16'hbe46, 16'hbe4a, 16'hbe4c, 16'hbe4e:
                dOp = cpudc_pkg::OP_CLRCTRL;
            16'b1011_1111_0100_01??: dOp = cpudc_pkg::OP_CMPAUX;
            16'b0111_0111_????_????: dOp = cpudc_pkg::OP_DMOVE;
            16'b1010_1111_????_????:
            begin
                dOp = cpudc_pkg::OP_PORTIN;
                dTwo = 1'b1;
                dCyc = cpudc_pkg::CYC_TWO;
            end
            16'b1011_1111_1000_????:
            begin
                dOp = cpudc_pkg::OP_ACCLONG;
                dTwo = 1'b1;
                dCyc = cpudc_pkg::CYC_TWO;
            end
            16'b0110_1011_????_????: dOp = cpudc_pkg::OP_ACCTEMP;
            16'b1011_1001_????_????:
            begin
                dOp = cpudc_pkg::OP_ACCIMM;
                dImm = {8'h00, fetchWord[7:0]};
            end
            16'b0110_1001_????_????: dOp = cpudc_pkg::OP_ACCLOWZ;
            16'b0110_1010_????_????: dOp = cpudc_pkg::OP_ACCHIGHZ;
            16'b1011_0???_????_????:
            begin
                dOp = cpudc_pkg::OP_AUXIMM;
                dCyc = cpudc_pkg::CYC_TWO;
                dImm = {8'h00, fetchWord[7:0]};
            end
            16'b0000_0???_????_????:
            begin
                dOp = cpudc_pkg::OP_AUXMEM;
                dCyc = cpudc_pkg::CYC_TWO;
            end
            16'b1011_1111_0000_1???:
            begin
                dOp = cpudc_pkg::OP_AUXLONG;
                dTwo = 1'b1;
                dCyc = cpudc_pkg::CYC_TWO;
            end
            16'b1011_110?_????_????:
            begin
                dOp = cpudc_pkg::OP_PAGEIMM;
                dCyc = cpudc_pkg::CYC_TWO;
                dImm = {7'h00, fetchWord[8:0]};
            end
            16'b0000_1101_????_????:
            begin
                dOp = cpudc_pkg::OP_PAGEMEM;
                dCyc = cpudc_pkg::CYC_TWO;
            end
            16'b0000_1110_????_????:
            begin
                dOp = cpudc_pkg::OP_STAT0;
                dCyc = cpudc_pkg::CYC_TWO;
            end
            16'b0000_1111_????_????:
            begin
                dOp = cpudc_pkg::OP_STAT1;
                dCyc = cpudc_pkg::CYC_TWO;
            end
            16'b0111_0011_????_????: dOp = cpudc_pkg::OP_TMPLOAD;
            16'b0111_0000_????_????: dOp = cpudc_pkg::OP_TMPACC;
            16'b0111_0001_????_????: dOp = cpudc_pkg::OP_TMPPROD;
            16'b0111_0010_????_????: dOp = cpudc_pkg::OP_TMPACCMOV;
            16'b0111_0100_????_????: dOp = cpudc_pkg::OP_TMPSUB;
            16'b0111_0101_????_????: dOp = cpudc_pkg::OP_PRODHI;
            default: dOp = cpudc_pkg::OP_NONE;
        endcase
    end

    // Flags are sampled when the target word arrives, the latest safe point
    assign finCyc = condBus.met ? cpudc_pkg::CYC_TAKEN : cpudc_pkg::CYC_SKIP;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.valid = 1'b0;
        unique case (st_ff.fsm)
            cpudc_pkg::ST_FIRST:
            begin
                if (fetchValid)
                begin
                    nxt_st.word = fetchWord;
                    nxt_st.op = dOp;
                    nxt_st.twoWord = dTwo;
                    nxt_st.cycles = dCyc;
                    nxt_st.unknown = dOp == cpudc_pkg::OP_NONE;
                    nxt_st.condMet = 1'b0;
                    nxt_st.imm = dImm;
                    if (dTwo)
                    begin
                        // Next word bypasses decode and becomes the operand
                        nxt_st.fsm = cpudc_pkg::ST_OPERAND;
                        nxt_st.expectOp = 1'b1;
                    end
                    else
                    begin
                        nxt_st.valid = 1'b1;
                        nxt_st.hold = dCyc - cpudc_pkg::CYC_ONE;
                        nxt_st.ready = dCyc == cpudc_pkg::CYC_ONE;
                        nxt_st.fsm = (dCyc == cpudc_pkg::CYC_ONE) ?
                            cpudc_pkg::ST_FIRST : cpudc_pkg::ST_HOLD;
                    end
                end
            end
            cpudc_pkg::ST_OPERAND:
            begin
                if (fetchValid)
                begin
                    nxt_st.imm = fetchWord;
                    nxt_st.expectOp = 1'b0;
                    nxt_st.valid = 1'b1;
                    if (st_ff.op == cpudc_pkg::OP_BRANCH)
                    begin
                        nxt_st.condMet = condBus.met;
                        nxt_st.cycles = finCyc;
                        nxt_st.hold = finCyc - cpudc_pkg::WORDS_TWO;
                    end
                    else
                    begin
                        nxt_st.hold = st_ff.cycles - cpudc_pkg::WORDS_TWO;
                    end
                    if ((st_ff.op == cpudc_pkg::OP_BRANCH ? finCyc : st_ff.cycles)
                        == cpudc_pkg::WORDS_TWO)
                    begin
                        nxt_st.fsm = cpudc_pkg::ST_FIRST;
                        nxt_st.ready = 1'b1;
                    end
                    else
                    begin
                        nxt_st.fsm = cpudc_pkg::ST_HOLD;
                        nxt_st.ready = 1'b0;
                    end
                end
            end
            cpudc_pkg::ST_HOLD:
            begin
                // Fetch is stalled while the datapath finishes extra cycles
                nxt_st.hold = st_ff.hold - 3'h1;
                if (st_ff.hold == 3'h1)
                begin
                    nxt_st.fsm = cpudc_pkg::ST_FIRST;
                    nxt_st.ready = 1'b1;
                end
            end
            default:
            begin
                nxt_st.fsm = cpudc_pkg::ST_FIRST;
                nxt_st.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_ff <= '{fsm: cpudc_pkg::ST_FIRST, hold: 3'h0, word: 16'h0000,
                imm: 16'h0000, op: cpudc_pkg::OP_NONE, cycles: 3'h1, twoWord: 1'b0,
                condMet: 1'b0, unknown: 1'b0, valid: 1'b0, ready: 1'b1,
                expectOp: 1'b0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign fetchReady = st_ff.ready;
    assign decExpectOperand = st_ff.expectOp;
    assign decValid = st_ff.valid;
    assign decOp = st_ff.op;
    assign decUnknown = st_ff.unknown;
    assign decTwoWord = st_ff.twoWord;
    assign decCycles = st_ff.cycles;
    assign decCondMet = st_ff.condMet;
    assign decWord = st_ff.word;
    assign decImm = st_ff.imm;

    AST_BRANCH_TAKEN: assert property (@(posedge clk) disable iff (rst)
        decValid && decOp == cpudc_pkg::OP_BRANCH && decCondMet
        |-> !fetchReady ##1 !fetchReady ##1 fetchReady)
        else $error("taken branch did not stall two cycles");
    AST_BRANCH_SKIP: assert property (@(posedge clk) disable iff (rst)
        decValid && decOp == cpudc_pkg::OP_BRANCH && !decCondMet
        |-> fetchReady && decCycles == 3'h2)
        else $error("skipped branch stalled");
    AST_BRANCH_EQZ: assert property (@(posedge clk) disable iff (rst)
        decValid && decOp == cpudc_pkg::OP_BRANCH && decWord[7:0] == 8'h88
        |-> decCondMet == $past(accZero))
        else $error("equal-zero branch condition wrong");
    AST_BLOCK_MOVE: assert property (@(posedge clk) disable iff (rst)
        decValid && (decOp == cpudc_pkg::OP_BLKSRC || decOp == cpudc_pkg::OP_BLKPROG)
        |-> decTwoWord && !fetchReady ##1 fetchReady)
        else $error("block move not two words three cycles");
    AST_OPERAND_PHASE: assert property (@(posedge clk) disable iff (rst)
        decValid && decTwoWord |-> $past(decExpectOperand) && !decExpectOperand)
        else $error("two-word opcode did not take an operand word");
    AST_ONE_CYCLE: assert property (@(posedge clk) disable iff (rst)
        fetchReady && fetchValid && !decExpectOperand && fetchWord[15:8] == 8'hb9
        |=> decValid && decOp == cpudc_pkg::OP_ACCIMM && fetchReady
            && decImm == {8'h00, $past(fetchWord[7:0])})
        else $error("short accumulator load mis-decoded");
    AST_SET_NOT_CLEAR: assert property (@(posedge clk) disable iff (rst)
        fetchReady && fetchValid && !decExpectOperand && fetchWord == 16'hbe41
        |=> decValid && decUnknown)
        else $error("set opcode taken as a clear");
    AST_AUX_SHORT: assert property (@(posedge clk) disable iff (rst)
        decValid && decOp == cpudc_pkg::OP_AUXIMM
        |-> !decTwoWord && !fetchReady ##1 fetchReady)
        else $error("short aux load not one word two cycles");
    AST_PAGE_IMM: assert property (@(posedge clk) disable iff (rst)
        decValid && decOp == cpudc_pkg::OP_PAGEIMM |-> decImm == {7'h00, decWord[8:0]})
        else $error("page immediate wrong");
    AST_PORT_IN: assert property (@(posedge clk) disable iff (rst)
        decValid && decOp == cpudc_pkg::OP_PORTIN |-> decTwoWord && fetchReady)
        else $error("port input not two words two cycles");

    COV_TAKEN: cover property (@(posedge clk) disable iff (rst)
        decValid && decOp == cpudc_pkg::OP_BRANCH && decCondMet);
    COV_SKIP: cover property (@(posedge clk) disable iff (rst)
        decValid && decOp == cpudc_pkg::OP_BRANCH && !decCondMet);
    COV_MOVE: cover property (@(posedge clk) disable iff (rst)
        decValid && decOp == cpudc_pkg::OP_BLKDST);
    COV_BACK2BACK: cover property (@(posedge clk) disable iff (rst)
        decValid && decCycles == 3'h1 ##1 decValid);
endmodule : cpudc_decoder

//--- verilog/cpudc_pkg.sv
// Purpose: Shared constants and types of the opcode decoder slice
// Assumes: 16-bit program words, one word offered per cycle at most
// Notes: Opcode patterns are matched in the decoder; positions live here
package cpudc_pkg;
    // Condition field layout of conditional branches
    localparam int MASK_LSB = 0;
    localparam int STATE_LSB = 4;
    localparam int PAIR_LSB = 8;
    localparam logic [1:0] PAIR_PIN_LOW = 2'h0;
    localparam logic [1:0] PAIR_TEST_SET = 2'h1;
    localparam logic [1:0] PAIR_TEST_CLR = 2'h2;
    localparam logic [1:0] PAIR_NONE = 2'h3;
    // Cycle counts per instruction class
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_TWO = 3'h2;
    localparam logic [2:0] CYC_MOVE = 3'h3;
    localparam logic [2:0] CYC_TAKEN = 3'h4;
    localparam logic [2:0] CYC_SKIP = 3'h2;
    localparam logic [2:0] WORDS_TWO = 3'h2;
    localparam logic [15:0] RST_WORD = 16'h0000;

    typedef enum logic [2:0]
    {
        ST_FIRST = 3'h1,
        ST_OPERAND = 3'h2,
        ST_HOLD = 3'h4
    } cpudc_state_e;

    typedef enum logic [4:0]
    {
        OP_NONE, OP_BRANCH, OP_BITTEST, OP_BITTEMP, OP_BLKSRC, OP_BLKDST,
        OP_BLKPROG, OP_CLRCTRL, OP_CMPAUX, OP_DMOVE, OP_PORTIN, OP_ACCLONG,
        OP_ACCTEMP, OP_ACCIMM, OP_ACCLOWZ, OP_ACCHIGHZ, OP_AUXIMM, OP_AUXMEM,
        OP_AUXLONG, OP_PAGEIMM, OP_PAGEMEM, OP_STAT0, OP_STAT1, OP_TMPLOAD,
        OP_TMPACC, OP_TMPPROD, OP_TMPACCMOV, OP_TMPSUB, OP_PRODHI
    } cpudc_op_e;

    typedef struct packed
    {
        cpudc_state_e fsm;
        logic [2:0] hold;
        logic [15:0] word;
        logic [15:0] imm;
        cpudc_op_e op;
        logic [2:0] cycles;
        logic twoWord;
        logic condMet;
        logic unknown;
        logic valid;
        logic ready;
        logic expectOp;
    } cpudc_regs_s;
endpackage : cpudc_pkg

//--- verilog/cpudc_cond_if.sv
// Purpose: Carries an instruction word and core flags to the condition evaluator
// Assumes: Evaluation is combinational
// Notes: Flag order matches the four-bit mask, zero in the top bit
interface cpudc_cond_if;
    logic [15:0] word;
    logic accZero;
    logic accNeg;
    logic ovfFlag;
    logic carryFlag;
    logic testFlag;
    logic ioPinLow;
    logic met;
    modport src (output word, output accZero, output accNeg, output ovfFlag,
        output carryFlag, output testFlag, output ioPinLow, input met);
    modport eval (input word, input accZero, input accNeg, input ovfFlag,
        input carryFlag, input testFlag, input ioPinLow, output met);
endinterface : cpudc_cond_if

//--- verilog/cpudc_cond_eval.sv
// Purpose: Decides whether a conditional instruction's condition holds
// Assumes: Word holds mask in bits 3:0, wanted states in 7:4, pair in 9:8
// Notes: An empty mask and pair value 3 together mean always met
module cpudc_cond_eval
(
    cpudc_cond_if.eval cif
);
    logic [3:0] flagsNow;
    logic [3:0] mask;
    logic [3:0] want;
    logic flagsOk;
    logic pairOk;

    always_comb
    begin
        flagsNow = {cif.accZero, cif.accNeg, cif.ovfFlag, cif.carryFlag};
        mask = cif.word[cpudc_pkg::MASK_LSB +: 4];
        want = cif.word[cpudc_pkg::STATE_LSB +: 4];
        // Only masked flags must equal their wanted state
        flagsOk = ((flagsNow ~^ want) & mask) == mask;
        unique case (cif.word[cpudc_pkg::PAIR_LSB +: 2])
            cpudc_pkg::PAIR_PIN_LOW: pairOk = cif.ioPinLow;
            cpudc_pkg::PAIR_TEST_SET: pairOk = cif.testFlag;
            cpudc_pkg::PAIR_TEST_CLR: pairOk = !cif.testFlag;
            cpudc_pkg::PAIR_NONE: pairOk = 1'b1;
        endcase
        cif.met = flagsOk && pairOk;
    end
endmodule : cpudc_cond_eval

//--- dv/cpudc_fetch_model.sv
// Purpose: Program fetch model that offers queued words to the decoder
// Assumes: The bench queues words with push; offers change at the falling edge
// Notes: An idle bus toggles its last word so stale data never looks valid
module cpudc_fetch_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic fetchReady,
    output logic fetchValid,
    output logic [15:0] fetchWord
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] q[$];
    logic tk;
    bit slow;
    initial
    begin
        fetchValid = 1'b0;
        fetchWord = 16'h0000;
        tk = 1'b0;
        slow = 1'b0;
    end
    task automatic push(input logic [15:0] w);
        q.push_back(w);
    endtask : push
    always @(posedge clk or posedge rst)
        tk <= rst ? 1'b0 : (fetchValid & fetchReady);
    // An offer is held until a sampled handshake, so a stall never drops a word
    always @(negedge clk)
    begin
        if (tk)
            void'(q.pop_front());
        if (tk || !fetchValid)
        begin
            if (q.size() > 0 && !(slow && $urandom_range(1) == 0))
            begin
                fetchValid <= 1'b1;
                fetchWord <= q[0];
            end
            else
            begin
                fetchValid <= 1'b0;
                fetchWord <= ~fetchWord;
            end
        end
    end
endmodule : cpudc_fetch_model

//--- dv/cpu_opcode_decode_part_tb.sv
// Purpose: Self-checking bench of the opcode decoder slice
// Assumes: Flags stay still while an instruction is in flight
// Notes: Random opcodes come from a prefix table except every fourth, which is a raw random word; corners are listed by hand
module cpu_opcode_decode_part_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed
    {
        cpudc_pkg::cpudc_op_e op;
        logic [2:0] cyc;
        logic two;
        logic met;
        logic [15:0] imm;
    } cpudc_exp_s;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic fetchValid, accZero, accNeg, ovfFlag, carryFlag, testFlag, ioPinLow;
    logic fetchReady, decExpectOperand, decValid, decUnknown, decTwoWord, decCondMet;
    logic [15:0] fetchWord, decWord, decImm;
    logic [2:0] decCycles;
    cpudc_pkg::cpudc_op_e decOp;
    int fails = 0;
    int check_count = 0;
    logic [31:0] pick [23] = '{32'he30000ff, 32'h40000fff, 32'h6f0000ff, 32'ha80000ff,
        32'ha90000ff, 32'ha50000ff, 32'hbe40000f, 32'hbf440003, 32'h770000ff, 32'haf0000ff,
        32'hbf80000f, 32'h6b0000ff, 32'hb90000ff, 32'h690000ff, 32'h6a0000ff, 32'hb00007ff,
        32'h000007ff, 32'hbf080007, 32'hbc0001ff, 32'h0d0000ff, 32'h0e0000ff, 32'h700007ff,
        32'h0f0000ff};
    always #2 clk = ~clk;
    cpudc_decoder DUT (.clk(clk), .rst(rst), .fetchValid(fetchValid), .fetchWord(fetchWord),
        .accZero(accZero), .accNeg(accNeg), .ovfFlag(ovfFlag), .carryFlag(carryFlag),
        .testFlag(testFlag), .ioPinLow(ioPinLow), .fetchReady(fetchReady),
        .decExpectOperand(decExpectOperand), .decValid(decValid), .decOp(decOp),
        .decUnknown(decUnknown), .decTwoWord(decTwoWord), .decCycles(decCycles),
        .decCondMet(decCondMet), .decWord(decWord), .decImm(decImm));
    cpudc_fetch_model m (.clk(clk), .rst(rst), .fetchReady(fetchReady),
        .fetchValid(fetchValid), .fetchWord(fetchWord));
    function automatic cpudc_exp_s mk(cpudc_pkg::cpudc_op_e op, logic [3:0] tc);
        return '{op, tc[2:0], tc[3], 1'b0, 16'h0000};
    endfunction : mk
    function automatic cpudc_exp_s expect_of(logic [15:0] w, logic [15:0] w1, logic [3:0] f);
        cpudc_exp_s e;
        casez (w)
            16'he3??: e = mk(cpudc_pkg::OP_BRANCH, 4'ha);
            16'h4???: e = mk(cpudc_pkg::OP_BITTEST, 4'h1);
            16'h6f??: e = mk(cpudc_pkg::OP_BITTEMP, 4'h1);
            16'ha8??: e = mk(cpudc_pkg::OP_BLKSRC, 4'hb);
            16'ha9??: e = mk(cpudc_pkg::OP_BLKDST, 4'hb);
            16'ha5??: e = mk(cpudc_pkg::OP_BLKPROG, 4'hb);
            16'hbe40, 16'hbe42, 16'hbe44, 16'hbe46, 16'hbe4a, 16'hbe4c, 16'hbe4e:
                e = mk(cpudc_pkg::OP_CLRCTRL, 4'h1);
            16'hbf4?: e = mk(w[3:2] == 2'h1 ? cpudc_pkg::OP_CMPAUX : cpudc_pkg::OP_NONE, 4'h1);
            16'h77??: e = mk(cpudc_pkg::OP_DMOVE, 4'h1);
            16'haf??: e = mk(cpudc_pkg::OP_PORTIN, 4'ha);
            16'hbf8?: e = mk(cpudc_pkg::OP_ACCLONG, 4'ha);
            16'h6b??: e = mk(cpudc_pkg::OP_ACCTEMP, 4'h1);
            16'hb9??: e = mk(cpudc_pkg::OP_ACCIMM, 4'h1);
            16'h69??: e = mk(cpudc_pkg::OP_ACCLOWZ, 4'h1);
            16'h6a??: e = mk(cpudc_pkg::OP_ACCHIGHZ, 4'h1);
            16'b1011_0???_????_????: e = mk(cpudc_pkg::OP_AUXIMM, 4'h2);
            16'b0000_0???_????_????: e = mk(cpudc_pkg::OP_AUXMEM, 4'h2);
            16'b1011_1111_0000_1???: e = mk(cpudc_pkg::OP_AUXLONG, 4'ha);
            16'b1011_110?_????_????: e = mk(cpudc_pkg::OP_PAGEIMM, 4'h2);
            16'h0d??: e = mk(cpudc_pkg::OP_PAGEMEM, 4'h2);
            16'h0e??: e = mk(cpudc_pkg::OP_STAT0, 4'h2);
            16'h0f??: e = mk(cpudc_pkg::OP_STAT1, 4'h2);
            16'h70??: e = mk(cpudc_pkg::OP_TMPACC, 4'h1);
            16'h71??: e = mk(cpudc_pkg::OP_TMPPROD, 4'h1);
            16'h72??: e = mk(cpudc_pkg::OP_TMPACCMOV, 4'h1);
            16'h73??: e = mk(cpudc_pkg::OP_TMPLOAD, 4'h1);
            16'h74??: e = mk(cpudc_pkg::OP_TMPSUB, 4'h1);
            16'h75??: e = mk(cpudc_pkg::OP_PRODHI, 4'h1);
            default: e = mk(cpudc_pkg::OP_NONE, 4'h1);
        endcase
        if (e.two)
            e.imm = w1;
        if (e.op == cpudc_pkg::OP_ACCIMM || e.op == cpudc_pkg::OP_AUXIMM)
            e.imm = {8'h00, w[7:0]};
        if (e.op == cpudc_pkg::OP_PAGEIMM)
            e.imm = {7'h00, w[8:0]};
        e.met = e.op == cpudc_pkg::OP_BRANCH && ((f ^ w[7:4]) & w[3:0]) == 4'h0;
        if (e.met)
            e.cyc = 3'h4;
        return e;
    endfunction : expect_of
    task automatic chk(logic [15:0] got, logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out();
        if (fails == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out
    task automatic run(logic [15:0] w0, logic [15:0] w1);
        cpudc_exp_s e;
        int n;
        n = 0;
        // A zero-stall op leaves its decValid pulse standing; let it pass first
        do
        begin
            @(negedge clk);
            n++;
        end
        while ((m.q.size() != 0 || fetchReady !== 1'b1 || decValid === 1'b1) && n < 40);
        {accZero, accNeg, ovfFlag, carryFlag, testFlag, ioPinLow} = 6'($urandom);
        e = expect_of(w0, w1, {accZero, accNeg, ovfFlag, carryFlag});
        m.push(w0);
        if (e.two)
            m.push(w1);
        n = 0;
        while (decValid !== 1'b1 && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        chk(16'(decValid), 16'h0001);
        chk(16'(decOp), 16'(e.op));
        chk(16'(decUnknown), 16'(e.op == cpudc_pkg::OP_NONE));
        chk(16'(decTwoWord), 16'(e.two));
        chk(16'(decExpectOperand), 16'h0000);
        chk(16'(decCycles), 16'(e.cyc));
        chk(16'(decCondMet), 16'(e.met));
        chk(decImm, e.imm);
        chk(decWord, w0);
        n = 0;
        while (fetchReady === 1'b0 && n < 8)
        begin
            n++;
            @(negedge clk);
        end
        chk(16'(n), 16'(e.cyc - (e.two ? 3'h2 : 3'h1)));
    endtask : run
    initial
    begin
        #200000;
        fails++;
        close_out();
    end
    initial
    begin
        int n;
        logic [31:0] p;
        void'($urandom(32'h0504));
        {accZero, accNeg, ovfFlag, carryFlag, testFlag, ioPinLow} = 6'h00;
        repeat (12) @(negedge clk);
        chk(16'(fetchReady), 16'h0001);
        chk(16'(decValid), 16'h0000);
        chk(16'(decCycles), 16'h0001);
        rst = 1'b0;
        run(16'he388, 16'h8123);
        run(16'he308, 16'h8456);
        run(16'he322, 16'h8789);
        run(16'h4c12, 16'h0000);
        run(16'h6f12, 16'h0000);
        // Block move addresses stay high, clear of the protected registers
        run(16'ha812, 16'h8100);
        run(16'ha912, 16'h8200);
        run(16'ha512, 16'h8300);
        for (int k = 0; k < 16; k++)
            run(16'hbe40 | 16'(k), 16'h0000);
        for (int k = 0; k < 4; k++)
            run(16'hbf44 | 16'(k), 16'h0000);
        run(16'h7712, 16'h0000);
        run(16'haf12, 16'hfedc);
        run(16'hbf8f, 16'h1234);
        run(16'h6b12, 16'h0000);
        run(16'hb900, 16'h0000);
        run(16'hb9ff, 16'h0000);
        run(16'h6912, 16'h0000);
        run(16'h6a12, 16'h0000);
        run(16'hb7ff, 16'h0000);
        run(16'h0012, 16'h0000);
        run(16'hbf0f, 16'habcd);
        run(16'hbdff, 16'h0000);
        run(16'h0d12, 16'h0000);
        run(16'h0e12, 16'h0000);
        run(16'h0f12, 16'h0000);
        for (int k = 0; k < 6; k++)
            run(16'h7012 | 16'(k << 8), 16'h0000);
        run(16'h8b00, 16'h0000);
        m.slow = 1'b1;
        for (int i = 0; i < 300; i++)
        begin
            p = pick[$urandom_range(22)];
            run(i % 4 == 0 ? 16'($urandom) : p[31:16] | (16'($urandom) & p[15:0]),
                16'h8000 | 16'($urandom));
        end
        m.slow = 1'b0;
        run(16'h7300, 16'h0000);
        @(negedge clk);
        for (int k = 0; k < 6; k++)
            m.push(16'h7012 | 16'(k << 8));
        n = 0;
        while (decValid !== 1'b1 && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (decValid === 1'b1 && n < 10)
        begin
            @(negedge clk);
            n++;
        end
        chk(16'(n), 16'h0006);
        close_out();
    end
endmodule : cpu_opcode_decode_part_tb
